// *** hw/bcro_pkg.sv ***
// Package: boot configuration byte layout, defaults and boot phases
package bcro_pkg;
  localparam logic [2:0] CFG_BYTE_ADDR   = 3'h7;   // Config byte at boot memory address 7
  localparam int         CFG_HS_DIS_BIT  = 7;      // Full-speed-only start
  localparam int         CFG_DISC_BIT    = 6;      // Come up disconnected
  localparam int         CFG_FAST_BIT    = 0;      // Fast serial boot bus
  localparam logic [7:0] CFG_DEFAULT     = 8'h00;  // Applied with no valid boot memory
  localparam logic       DISC_RESET      = 1'b0;   // Connected
  localparam logic       FAST_RESET      = 1'b0;   // About 100 kHz
  localparam logic       OWNER_RESET     = 1'b0;   // Built-in default device answers
  localparam logic [7:0] EP_PRESET_MASK  = 8'h0f;  // Preset endpoint group
  localparam logic [7:0] EP_NONE         = 8'h00;

  // Boot source reported by the loader
  typedef enum logic [1:0] {
    BCRO_SRC_NONE = 2'h0,
    BCRO_SRC_ID   = 2'h1,   // identity_only_boot
    BCRO_SRC_CODE = 2'h3    // code_image_boot
  } bcro_src_e;

  // Boot sequencing, Gray coded
  typedef enum logic [1:0] {
    BCRO_ST_LOAD = 2'b00,
    BCRO_ST_APPLY = 2'b01,
    BCRO_ST_RUN  = 2'b11
  } bcro_state_e;

  // Byte delivered by the boot memory loader
  typedef struct packed {
    logic       valid;
    logic [2:0] addr;
    logic [7:0] data;
  } bcro_byte_s;

  // Firmware write to the control bits
  typedef struct packed {
    logic wr_disc;
    logic disc;
    logic wr_owner;
    logic owner;
    logic wr_fast;
    logic fast;
  } bcro_fw_wr_s;
endpackage

// *** hw/bcro_boot_cfg.sv ***
// Boot configuration loader and endpoint-zero request owner flag
//
// Overview of operation
// - Config byte means the same for identity-only and code-image boots.
// - Bit 7 set forces full-speed start, no high-speed.
// - Bit 6 set sets soft-disconnect before processor release.
// - Soft-disconnect resets to zero, connected, unless config byte overrides.
// - Bit 6 zero never forces connect; default kept.
// - After processor release firmware may change soft-disconnect freely.
// - Disconnect floats pull-up supply; connect drives it.
// - Bit 0 selects serial boot speed: 0 about 100 kHz, 1 about 400 kHz.
// - Speed bit copied into serial bus control bit 0, reset zero.
// - Request-owner flag is zero at power-on reset.
// - Firmware writing owner one routes endpoint-zero requests to firmware.
// - Owner set when external code at 0, pin high, no custom ids.
// - Code-image boot with pin low sets owner and runs from RAM.
// - Preset endpoints enabled and reported before processor release.
// - Config byte read from boot memory address 7.
module bcro_boot_cfg
  import bcro_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire bcro_byte_s  boot_byte,
  input  wire logic        boot_done,
  input  wire bcro_src_e   boot_src,
  input  wire logic        external_code_select,
  input  wire logic        code_at_zero_ext,
  input  wire bcro_fw_wr_s fw_wr,
  output logic             cpu_hold_reset,
  output logic             run_from_ram,
  output logic             usb_soft_disconnect,
  output logic             pullup_supply_out,
  output logic             pullup_supply_oe,
  output logic             serial_fast_speed_sel,
  output logic [7:0]       serial_bus_control_reg,
  output logic             full_speed_only,
  output logic             request_owner_flag,
  output logic             req_to_firmware,
  output logic [7:0]       ep_preset_en
);

  bcro_state_e state_r;
  logic [7:0]  cfg_r;
  logic        cfg_seen_r;
  logic        disc_r;
  logic        fast_r;
  logic        hs_dis_r;
  logic        owner_r;
  logic        ram_r;
  logic [7:0]  ep_r;
  logic        cfg_take;

  // On-chip code-image boot: firmware owns requests and runs from RAM
  function automatic logic code_boot_on_chip(bcro_src_e src, logic ext_sel);
    return (src == BCRO_SRC_CODE) && !ext_sel;
  endfunction

  // Config byte accepted only during load and only at its address
  assign cfg_take = (state_r == BCRO_ST_LOAD) && boot_byte.valid &&
                    (boot_byte.addr == CFG_BYTE_ADDR) &&
                    (boot_src != BCRO_SRC_NONE);

  // Boot sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= BCRO_ST_LOAD;
    end else begin
      case (state_r)
        BCRO_ST_LOAD:  if (boot_done) state_r <= BCRO_ST_APPLY;
        BCRO_ST_APPLY: state_r <= BCRO_ST_RUN;
        BCRO_ST_RUN:   state_r <= BCRO_ST_RUN;
        default:       state_r <= BCRO_ST_LOAD;
      endcase
    end
  end

  // Capture config byte once; defaults otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r      <= CFG_DEFAULT;
      cfg_seen_r <= 1'b0;
    end else if (cfg_take && !cfg_seen_r) begin
      cfg_r      <= boot_byte.data;
      cfg_seen_r <= 1'b1;
    end
  end

  // Soft-disconnect control bit
  always_ff @(posedge clk) begin
    if (rst) begin
      disc_r <= DISC_RESET;
    end else if (state_r == BCRO_ST_APPLY) begin
      if (cfg_r[CFG_DISC_BIT]) disc_r <= 1'b1;
    end else if (state_r == BCRO_ST_RUN && fw_wr.wr_disc) begin
      disc_r <= fw_wr.disc;
    end
  end

  // Serial bus speed, copied into control bit 0
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_r <= FAST_RESET;
    end else if (state_r == BCRO_ST_APPLY) begin
      fast_r <= cfg_r[CFG_FAST_BIT];
    end else if (state_r == BCRO_ST_RUN && fw_wr.wr_fast) begin
      fast_r <= fw_wr.fast;
    end
  end

  // Full-speed-only start
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_dis_r <= 1'b0;
    end else if (state_r == BCRO_ST_APPLY) begin
      hs_dis_r <= cfg_r[CFG_HS_DIS_BIT];
    end
  end

  // Request owner flag
  always_ff @(posedge clk) begin
    if (rst) begin
      owner_r <= OWNER_RESET;
    end else if (state_r == BCRO_ST_APPLY) begin
      if (boot_src == BCRO_SRC_NONE && external_code_select && code_at_zero_ext) begin
        owner_r <= 1'b1;
      end else if (code_boot_on_chip(boot_src, external_code_select)) begin
        owner_r <= 1'b1;
      end
    end else if (state_r == BCRO_ST_RUN && fw_wr.wr_owner) begin
      owner_r <= fw_wr.owner;
    end
  end

  // Execution from on-chip RAM after code-image boot
  always_ff @(posedge clk) begin
    if (rst) begin
      ram_r <= 1'b0;
    end else if (state_r == BCRO_ST_APPLY) begin
      ram_r <= code_boot_on_chip(boot_src, external_code_select);
    end
  end

  // Preset endpoints enabled before release
  always_ff @(posedge clk) begin
    if (rst) begin
      ep_r <= EP_NONE;
    end else if (state_r == BCRO_ST_APPLY) begin
      ep_r <= EP_PRESET_MASK;
    end
  end

  // Outputs
  assign cpu_hold_reset         = (state_r != BCRO_ST_RUN);
  assign run_from_ram           = ram_r;
  assign usb_soft_disconnect    = disc_r;
  assign pullup_supply_out      = 1'b1;
  assign pullup_supply_oe       = !disc_r;
  assign serial_fast_speed_sel  = fast_r;
  assign serial_bus_control_reg = {7'h00, fast_r};
  assign full_speed_only        = hs_dis_r;
  assign request_owner_flag     = owner_r;
  assign req_to_firmware        = owner_r;
  assign ep_preset_en           = ep_r;

  // Assertions
  a_disc_before_run: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_APPLY && cfg_r[CFG_DISC_BIT]) |=> disc_r && cpu_hold_reset == 1'b0)
    else $error("disconnect not set at release");
  a_disc_keep: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_APPLY && !cfg_r[CFG_DISC_BIT]) |=> disc_r == $past(disc_r))
    else $error("zero config bit changed disconnect");
  a_disc_fw: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_RUN && fw_wr.wr_disc) |=> disc_r == $past(fw_wr.disc))
    else $error("firmware disconnect write lost");
  a_pullup_float: assert property (@(posedge clk) disable iff (rst)
    pullup_supply_oe == !usb_soft_disconnect)
    else $error("pull-up supply mismatch");
  a_speed_copy: assert property (@(posedge clk) disable iff (rst)
    state_r == BCRO_ST_APPLY |=> serial_bus_control_reg[0] == $past(cfg_r[CFG_FAST_BIT]))
    else $error("speed bit not copied");
  a_fs_only: assert property (@(posedge clk) disable iff (rst)
    state_r == BCRO_ST_APPLY |=> full_speed_only == $past(cfg_r[CFG_HS_DIS_BIT]))
    else $error("full-speed bit wrong");
  a_owner_code: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_APPLY && boot_src == BCRO_SRC_CODE && !external_code_select)
      |=> request_owner_flag && run_from_ram)
    else $error("code boot owner not set");
  a_owner_ext: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_APPLY && boot_src == BCRO_SRC_NONE && external_code_select &&
     code_at_zero_ext) |=> request_owner_flag)
    else $error("external code owner not set");
  a_owner_fw: assert property (@(posedge clk) disable iff (rst)
    (state_r == BCRO_ST_RUN && fw_wr.wr_owner) |=> req_to_firmware == $past(fw_wr.owner))
    else $error("owner write lost");
  a_ep_preset: assert property (@(posedge clk) disable iff (rst)
    !cpu_hold_reset |-> ep_preset_en == EP_PRESET_MASK)
    else $error("endpoints not preset at release");
  a_reset_state: assert property (@(posedge clk)
    rst |=> !usb_soft_disconnect && !request_owner_flag && cpu_hold_reset && pullup_supply_oe)
    else $error("outputs not at reset values");
  a_ctl_reset: assert property (@(posedge clk)
    rst |=> serial_bus_control_reg == 8'h00 && !serial_fast_speed_sel)
    else $error("serial bus control not reset");
  a_cfg_once: assert property (@(posedge clk) disable iff (rst)
    cfg_seen_r |=> cfg_r == $past(cfg_r))
    else $error("config byte sampled twice");
  a_cfg_addr: assert property (@(posedge clk) disable iff (rst)
    (!cfg_seen_r && boot_byte.valid && boot_byte.addr != CFG_BYTE_ADDR) |=> !cfg_seen_r)
    else $error("config byte taken from wrong address");

  c_disc_boot: cover property (@(posedge clk) disable iff (rst)
    state_r == BCRO_ST_APPLY ##1 disc_r);
  c_code_boot: cover property (@(posedge clk) disable iff (rst)
    state_r == BCRO_ST_APPLY && boot_src == BCRO_SRC_CODE);
  c_fw_reconnect: cover property (@(posedge clk) disable iff (rst)
    disc_r ##1 !disc_r);
  c_fs_start: cover property (@(posedge clk) disable iff (rst)
    state_r == BCRO_ST_APPLY ##1 full_speed_only);
endmodule

// *** test/bcro_boot_mem.sv ***
// Serial boot memory model: one image byte per cycle, then done
module bcro_boot_mem
  import bcro_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] cfg,
  input  wire bcro_src_e  src,
  output bcro_byte_s      boot_byte,
  output logic            boot_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = -1;
  logic [7:0] mark;

  initial begin
    boot_byte = '0;
    boot_done = 1'b0;
  end

  assign mark = (src == BCRO_SRC_CODE) ? 8'hc2 : 8'hc0;

  // Image walk; released data lines toggle while idle, outside the walk
  always @(posedge clk) begin
    if (n >= 0 && n < 8)
      boot_byte <= {1'b1, n[2:0], (n == 0) ? mark : (n == 7) ? (cfg & 8'hc1)
                    : 8'($urandom)};
    else
      boot_byte <= {1'b0, 3'h0, ~boot_byte.data};
    boot_done <= (n == 8);
    n <= go ? ((src == BCRO_SRC_NONE) ? 8 : 0) : (n >= 0 && n < 8) ? n + 1 : -1;
  end
endmodule

// *** test/bcro_boot_cfg_test.sv ***
// Testbench for the boot configuration loader
module bcro_boot_cfg_test
  import bcro_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, go = 0, ext = 0, caz = 0;
  logic [7:0]  cfg = '0, ec, ctl, ep;
  logic        eo, hold, ram, disc, oe, pout, fast, fs, own, r2f, bd;
  bcro_src_e   src = BCRO_SRC_NONE;
  bcro_src_e   st[3] = '{BCRO_SRC_NONE, BCRO_SRC_ID, BCRO_SRC_CODE};
  bcro_fw_wr_s fw_wr = '0;
  bcro_byte_s  bb;
  int          n_mismatch = 0, n_tests = 0, cyc = 0;

  bcro_boot_mem mem (.clk(clk), .go(go), .cfg(cfg), .src(src), .boot_byte(bb), .boot_done(bd));
  bcro_boot_cfg dut (.clk(clk), .rst(rst), .boot_byte(bb), .boot_done(bd), .boot_src(src),
    .external_code_select(ext), .code_at_zero_ext(caz), .fw_wr(fw_wr), .cpu_hold_reset(hold),
    .run_from_ram(ram), .usb_soft_disconnect(disc), .pullup_supply_out(pout),
    .pullup_supply_oe(oe), .serial_fast_speed_sel(fast), .serial_bus_control_reg(ctl),
    .full_speed_only(fs), .request_owner_flag(own), .req_to_firmware(r2f), .ep_preset_en(ep));

  // Clock and hang guard
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Boot each source with random pins and config, then firmware writes
  initial begin
    void'($urandom(32'hee41985a));
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      rst <= 1'b1;
      src <= st[i % 3];
      ext <= (i >= 3);
      caz <= (i < 6) ? (i[0] | 1'($urandom)) : 1'b0;
      cfg <= 8'($urandom);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("hold", hold, 8'h01);
      chk("oe", {oe, pout}, 8'h03);
      chk("own", own, 8'h00);
      chk("ctl", ctl, 8'h00);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      ec = (src == BCRO_SRC_NONE) ? 8'h00 : (cfg & 8'hc1);
      eo = (src == BCRO_SRC_CODE && !ext) || (src == BCRO_SRC_NONE && ext && caz);
      for (int k = 0; k < 40 && hold !== 1'b0; k++) begin
        @(posedge clk);
        #1;
      end
      chk("hold", hold, 8'h00);
      chk("disc", disc, ec[6]);
      chk("oe", oe, !ec[6]);
      chk("fast", fast, ec[0]);
      chk("ctl", ctl, {7'h0, ec[0]});
      chk("fs", fs, ec[7]);
      chk("own", {own, r2f}, {eo, eo});
      chk("ram", ram, src == BCRO_SRC_CODE && !ext);
      chk("ep", ep, EP_PRESET_MASK);
      // Owner first, then reconnect with fast speed
      @(posedge clk);
      fw_wr <= 6'h0c;
      @(posedge clk);
      fw_wr <= 6'h23;
      @(posedge clk);
      fw_wr <= '0;
      #1;
      chk("own", {own, r2f}, 8'h03);
      chk("disc", {disc, oe, fast}, 8'h03);
      // A late image with the opposite config must not be applied
      cfg <= ~cfg;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      chk("late", {disc, fs, hold, fast}, {4'h0, 1'b0, ec[7], 2'h1});
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule
